/* hdl/rstc_top.sv */
// Reset source controller: merges reset sources, records the cause.
// Assumes APB master on i_clk; pin, comparator, supply and watched
// clock inputs are asynchronous; other events come from i_clk logic.

module rstc_top #(
  parameter int MCD_TIMEOUT_CYC = rstc_pkg::RSTC_MCD_TIMEOUT_CYC,
  parameter int HOLD_CYC = rstc_pkg::RSTC_HOLD_CYC
) (
  // Clock and power-on reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [rstc_pkg::RSTC_ADDR_W-1:0] i_paddr,
  input wire logic [rstc_pkg::RSTC_DATA_W-1:0] i_pwdata,
  output logic [rstc_pkg::RSTC_DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Asynchronous sources
  input wire logic i_reset_pin_n,
  input wire logic i_comparator_out,
  input wire logic i_supply_low,
  input wire logic i_core_clock,
  // Power mode and comparator wake-up
  input wire logic i_low_power,
  input wire logic i_cmp_wake_en,
  // Watchdog
  input wire logic i_wdt_overflow,
  input wire logic i_wdt_disable,
  // Flash access checks
  input wire logic i_flash_write_enable,
  input wire logic i_flash_wr_above_lock,
  input wire logic i_flash_rd_above_lock,
  input wire logic i_fetch_above_lock,
  input wire logic i_flash_secure_block,
  input wire logic i_flash_wr_erase,
  // Real-time clock events
  input wire logic i_rtc_fail_det_en,
  input wire logic i_rtc_clk_slow,
  input wire logic i_rtc_alarm_en,
  input wire logic i_rtc_alarm_match,
  // Reset outputs
  output logic o_sys_reset,
  output logic o_reset_pin_out,
  output logic o_reset_pin_oe_n,
  output logic o_supply_mon_en,
  output logic o_wdt_enable,
  output logic o_wdt_tick
);

  localparam int HOLD_W = $clog2(HOLD_CYC + 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC - 1);
  localparam logic [3:0] WDT_LAST = 4'(rstc_pkg::RSTC_WDT_DIV - 1);

  // ----------------------------------------------------------------
  // Cause priority
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick_cause(input logic [7:0] src);
    logic [7:0] one;
    one = '0;
    if (src[rstc_pkg::RSTC_B_PWR]) one[rstc_pkg::RSTC_B_PWR] = 1'b1;
    else if (src[rstc_pkg::RSTC_B_PIN]) one[rstc_pkg::RSTC_B_PIN] = 1'b1;
    else if (src[rstc_pkg::RSTC_B_MCD]) one[rstc_pkg::RSTC_B_MCD] = 1'b1;
    else if (src[rstc_pkg::RSTC_B_CMP]) one[rstc_pkg::RSTC_B_CMP] = 1'b1;
    else if (src[rstc_pkg::RSTC_B_WDT]) one[rstc_pkg::RSTC_B_WDT] = 1'b1;
    else if (src[rstc_pkg::RSTC_B_FLASH]) one[rstc_pkg::RSTC_B_FLASH] = 1'b1;
    else if (src[rstc_pkg::RSTC_B_RTC]) one[rstc_pkg::RSTC_B_RTC] = 1'b1;
    else if (src[rstc_pkg::RSTC_B_SW]) one[rstc_pkg::RSTC_B_SW] = 1'b1;
    return one;
  endfunction : pick_cause

  rstc_pkg::rstc_state_t state_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic pin_n_s;
  logic cmp_s;
  logic supply_low_s;
  logic core_clk_s;
  logic [7:0] flags_q;
  logic [7:0] cause_q;
  logic [7:0] src_d;
  logic mcd_en_q;
  logic cmp_en_q;
  logic rtc_en_q;
  logic supply_en_q;
  logic sw_req_q;
  logic [HOLD_W-1:0] hold_q;
  logic level_hold;
  logic flash_fault;
  logic reg_hit;
  logic wr_fire;
  logic [3:0] div_q;
  logic [1:0] own_drv_q;
  rstc_mcd_if mcd_bus ();

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= 4'h1;
      sync2_q <= 4'h1;
    end else begin
      sync1_q <= {i_core_clock, i_supply_low, i_comparator_out, i_reset_pin_n};
      sync2_q <= sync1_q;
    end
  end

  assign pin_n_s = sync2_q[0];
  assign cmp_s = sync2_q[1];
  assign supply_low_s = sync2_q[2];
  assign core_clk_s = sync2_q[3];

  // ----------------------------------------------------------------
  // Clock loss detector
  // ----------------------------------------------------------------
  // gated in low power
  assign mcd_bus.enable = mcd_en_q && !i_low_power;
  assign mcd_bus.clk_level = core_clk_s;

  rstc_clk_loss #(
    .TIMEOUT_CYC(MCD_TIMEOUT_CYC)
  ) u_clk_loss (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .bus(mcd_bus)
  );

  // ----------------------------------------------------------------
  // Source collection
  // ----------------------------------------------------------------
  // illegal flash access
  assign flash_fault = (i_flash_wr_above_lock && i_flash_write_enable) ||
    i_flash_rd_above_lock || i_fetch_above_lock || i_flash_secure_block ||
    (i_flash_wr_erase && !supply_en_q);

  always_comb begin
    src_d = '0;
    // pin reset, not gated, echo of own pin drive masked
    src_d[rstc_pkg::RSTC_B_PIN] = !pin_n_s && o_reset_pin_oe_n && own_drv_q == '0;
    src_d[rstc_pkg::RSTC_B_PWR] = supply_low_s && supply_en_q;
    src_d[rstc_pkg::RSTC_B_MCD] = mcd_bus.timeout;
    // active low comparator, low power wake-up gate
    src_d[rstc_pkg::RSTC_B_CMP] = cmp_en_q && !cmp_s && (!i_low_power || i_cmp_wake_en);
    // watchdog overflow, gated in low power
    src_d[rstc_pkg::RSTC_B_WDT] = i_wdt_overflow && !i_low_power;
    src_d[rstc_pkg::RSTC_B_FLASH] = flash_fault;
    // oscillator fail, alarm, works in low power
    src_d[rstc_pkg::RSTC_B_RTC] = rtc_en_q && ((i_rtc_fail_det_en && i_rtc_clk_slow) ||
      (i_rtc_alarm_en && i_rtc_alarm_match));
    src_d[rstc_pkg::RSTC_B_SW] = sw_req_q;
  end

  assign level_hold = src_d[rstc_pkg::RSTC_B_PIN] || src_d[rstc_pkg::RSTC_B_PWR] ||
    src_d[rstc_pkg::RSTC_B_CMP];

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  // merge and record latest cause
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= rstc_pkg::RSTC_RUN;
      cause_q <= '0;
      hold_q <= '0;
      o_sys_reset <= 1'b1;
      flags_q <= rstc_pkg::RSTC_FLAGS_POR;
    end else begin
      unique case (state_q)
        rstc_pkg::RSTC_RUN: begin
          o_sys_reset <= 1'b0;
          hold_q <= '0;
          if (|src_d) begin
            state_q <= rstc_pkg::RSTC_HOLD;
            cause_q <= pick_cause(src_d);
            o_sys_reset <= 1'b1;
          end
        end
        rstc_pkg::RSTC_HOLD: begin
          if (hold_q != HOLD_LAST) begin
            hold_q <= hold_q + HOLD_W'(1);
          end else if (!level_hold) begin
            // flag set on exit, only latest cause
            state_q <= rstc_pkg::RSTC_RUN;
            flags_q <= cause_q;
            o_sys_reset <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Reset pin drive
  // ----------------------------------------------------------------
  // only supply resets drive the pin
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reset_pin_out <= 1'b0;
      o_reset_pin_oe_n <= 1'b1;
      own_drv_q <= '0;
    end else begin
      o_reset_pin_out <= 1'b0;
      own_drv_q <= {own_drv_q[0], !o_reset_pin_oe_n};
      o_reset_pin_oe_n <= !(state_q == rstc_pkg::RSTC_HOLD &&
        cause_q[rstc_pkg::RSTC_B_PWR]);
    end
  end

  // ----------------------------------------------------------------
  // Watchdog enable and clock divider
  // ----------------------------------------------------------------
  // enabled and divided by 12 after any reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wdt_enable <= 1'b1;
      div_q <= '0;
      o_wdt_tick <= 1'b0;
    end else if (o_sys_reset) begin
      o_wdt_enable <= 1'b1;
      div_q <= '0;
      o_wdt_tick <= 1'b0;
    end else begin
      if (i_wdt_disable) begin
        o_wdt_enable <= 1'b0;
      end
      o_wdt_tick <= (div_q == WDT_LAST);
      div_q <= (div_q == WDT_LAST) ? 4'h0 : div_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign reg_hit = (i_paddr == rstc_pkg::RSTC_CAUSE_ADDR);
  assign wr_fire = i_psel && i_penable && o_pready && i_pwrite && reg_hit &&
    state_q == rstc_pkg::RSTC_RUN;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !reg_hit;
      o_prdata <= '0;
      if (i_psel && !i_penable && !i_pwrite && reg_hit) begin
        o_prdata <= {{(rstc_pkg::RSTC_DATA_W - rstc_pkg::RSTC_REG_W){1'b0}}, flags_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // Source enables
  // ----------------------------------------------------------------
  // software enables kept across resets
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mcd_en_q <= rstc_pkg::RSTC_SRC_EN_POR;
      cmp_en_q <= rstc_pkg::RSTC_SRC_EN_POR;
      rtc_en_q <= rstc_pkg::RSTC_SRC_EN_POR;
    end else if (wr_fire) begin
      mcd_en_q <= i_pwdata[rstc_pkg::RSTC_B_MCD];
      cmp_en_q <= i_pwdata[rstc_pkg::RSTC_B_CMP];
      rtc_en_q <= i_pwdata[rstc_pkg::RSTC_B_RTC];
    end
  end

  // supply selection, only power resets restore it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      supply_en_q <= rstc_pkg::RSTC_SUPPLY_EN_POR;
      o_supply_mon_en <= rstc_pkg::RSTC_SUPPLY_EN_POR;
    end else begin
      if (state_q == rstc_pkg::RSTC_HOLD && cause_q[rstc_pkg::RSTC_B_PWR]) begin
        supply_en_q <= 1'b1;
      end else if (wr_fire) begin
        supply_en_q <= i_pwdata[rstc_pkg::RSTC_B_PWR];
      end
      o_supply_mon_en <= supply_en_q;
    end
  end

  // write of bit 4 requests a reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_req_q <= 1'b0;
    end else begin
      sw_req_q <= wr_fire && i_pwdata[rstc_pkg::RSTC_B_SW];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_pin_reset_entry: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_q == rstc_pkg::RSTC_RUN && !pin_n_s && o_reset_pin_oe_n && own_drv_q == '0) |=>
      o_sys_reset && cause_q != '0
  ) else $error("pin reset not entered");
  chk_cause_on_exit: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_q == rstc_pkg::RSTC_HOLD) ##1 (state_q == rstc_pkg::RSTC_RUN) |->
      flags_q == $past(cause_q) && $onehot(flags_q)
  ) else $error("cause flags differ from recorded cause");
  chk_lp_gating: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_low_power |-> !src_d[rstc_pkg::RSTC_B_WDT] && !mcd_bus.enable
  ) else $error("watchdog or clock loss active in low power");
  chk_pin_untouched: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_reset_pin_oe_n |-> $past(o_sys_reset) && $past(cause_q[rstc_pkg::RSTC_B_PWR])
  ) else $error("reset pin driven by internal source");
  chk_wdt_after_reset: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_sys_reset) |-> o_wdt_enable and
      (##1 (!o_sys_reset) [*8] ##1 (!o_sys_reset) [*3] |=> o_wdt_tick)
  ) else $error("watchdog not enabled at divided rate");
  chk_sw_force: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    wr_fire && i_pwdata[rstc_pkg::RSTC_B_SW] |=> ##1 o_sys_reset
  ) else $error("software force did not reset");
  chk_cmp_reset: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_q == rstc_pkg::RSTC_RUN && cmp_en_q && !cmp_s && !i_low_power) |=> o_sys_reset
  ) else $error("comparator reset not entered");
  chk_flash_reset: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_q == rstc_pkg::RSTC_RUN && i_flash_rd_above_lock) |=> o_sys_reset
  ) else $error("flash fault did not reset");
  chk_supply_kept: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (!wr_fire && !(state_q == rstc_pkg::RSTC_HOLD && cause_q[rstc_pkg::RSTC_B_PWR])) |=>
      $stable(supply_en_q)
  ) else $error("supply selection changed by other reset");

endmodule : rstc_top

/* hdl/rstc_pkg.sv */
// Constants and types of the reset source controller.
// Assumes a 200 MHz system clock and an APB register port.
package rstc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RSTC_CAUSE_IDX = 8'hef;
  localparam logic [11:0] RSTC_CAUSE_ADDR = {2'h0, RSTC_CAUSE_IDX, 2'h0};
  localparam int RSTC_ADDR_W = 12;
  localparam int RSTC_DATA_W = 32;
  localparam int RSTC_REG_W = 8;

  // ----------------------------------------------------------------
  // Bit positions in the cause register
  // ----------------------------------------------------------------
  localparam int RSTC_B_PIN = 0;
  localparam int RSTC_B_PWR = 1;
  localparam int RSTC_B_MCD = 2;
  localparam int RSTC_B_WDT = 3;
  localparam int RSTC_B_SW = 4;
  localparam int RSTC_B_CMP = 5;
  localparam int RSTC_B_FLASH = 6;
  localparam int RSTC_B_RTC = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RSTC_FLAGS_POR = 8'h02;
  localparam logic RSTC_SUPPLY_EN_POR = 1'b1;
  localparam logic RSTC_SRC_EN_POR = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RSTC_CLK_MHZ = 200;
  localparam int RSTC_MCD_TIMEOUT_US = 100;
  localparam int RSTC_MCD_TIMEOUT_CYC = RSTC_MCD_TIMEOUT_US * RSTC_CLK_MHZ;
  localparam int RSTC_HOLD_CYC = 16;
  localparam int RSTC_WDT_DIV = 12;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSTC_RUN = 2'b01,
    RSTC_HOLD = 2'b10
  } rstc_state_t;

endpackage : rstc_pkg

/* hdl/rstc_mcd_if.sv */
// Link between the reset controller and its clock loss detector.
// Assumes both ends run on the same system clock.
interface rstc_mcd_if;
  logic enable;
  logic clk_level;
  logic timeout;

  modport ctl (output enable, output clk_level, input timeout);
  modport mon (input enable, input clk_level, output timeout);
endinterface : rstc_mcd_if

/* hdl/rstc_clk_loss.sv */
// Clock loss detector: times how long the watched clock holds a level.
// Assumes clk_level is already synchronised to i_clk.
module rstc_clk_loss #(
  parameter int TIMEOUT_CYC = rstc_pkg::RSTC_MCD_TIMEOUT_CYC,
  parameter int CNT_W = $clog2(TIMEOUT_CYC + 1)
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Controller side
  rstc_mcd_if.mon bus
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYC - 1);

  logic [CNT_W-1:0] cnt_q;
  logic level_q;
  logic timeout_q;

  // ----------------------------------------------------------------
  // Stuck level timer
  // ----------------------------------------------------------------
  // stuck clock timeout
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      level_q <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      level_q <= bus.clk_level;
      timeout_q <= 1'b0;
      if (!bus.enable || (bus.clk_level != level_q)) begin
        cnt_q <= '0;
      end else if (cnt_q == LAST) begin
        cnt_q <= '0;
        timeout_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  assign bus.timeout = timeout_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_mcd_full_window: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    timeout_q |-> $past(cnt_q) == LAST && $past(bus.enable)
  ) else $error("clock loss timeout without full stuck window");

endmodule : rstc_clk_loss

/* tb/rstc_src_model.sv */
// Far side model: external reset pin driver, comparator and watched clock.
// Assumes the bench steers its controls from the system clock domain.
module rstc_src_model (
  // Clock
  input wire logic i_clk,
  // Bench controls
  input wire logic i_pin_req,
  input wire logic i_cmp_trip,
  input wire logic i_clk_stop,
  // Source outputs
  output logic o_pin_drive_n,
  output logic o_comparator_out,
  output logic o_core_clock
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Pin and comparator
  // ------------------------------------------------------------
  // pin pulled low
  assign o_pin_drive_n = !i_pin_req;
  assign o_comparator_out = !i_cmp_trip;

  // ------------------------------------------------------------
  // Watched clock, toggles unless stopped
  // ------------------------------------------------------------
  initial o_core_clock = 1'b0;
  always @(posedge i_clk) begin
    if (!i_clk_stop) begin
      o_core_clock <= !o_core_clock;
    end
  end
endmodule : rstc_src_model

/* tb/tb_top.sv */
// Bench for the reset source controller: APB tasks and source scenarios.
// Assumes short detector and hold counts set through the parameters.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk, rst_n, psel, penable, pwrite, lp, wake, fwe, sup;
  logic pin_req, cmp_trip, clk_stop, serr, wdis;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata;
  logic [7:0] ev;
  logic [31:0] prdata;
  logic pready, pslverr, model_pin_n, cmp_out, core_clk;
  logic sys_reset, pin_out, pin_oe_n, smon, wdt_en, tick;
  wire pin_n;
  int mismatches, checks_done;

  // Pin with pull-up: design drives only while its enable is low
  assign pin_n = (!pin_oe_n) ? pin_out : model_pin_n;

  always #2.5 clk = !clk;

  rstc_top #(.MCD_TIMEOUT_CYC(40), .HOLD_CYC(4)) DUT (
    .i_clk(clk), .i_rst_n(rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_reset_pin_n(pin_n), .i_comparator_out(cmp_out),
    .i_supply_low(sup), .i_core_clock(core_clk),
    .i_low_power(lp), .i_cmp_wake_en(wake),
    .i_wdt_overflow(ev[0]), .i_wdt_disable(wdis),
    .i_flash_write_enable(fwe), .i_flash_wr_above_lock(ev[1]),
    .i_flash_rd_above_lock(ev[2]), .i_fetch_above_lock(ev[3]),
    .i_flash_secure_block(ev[4]), .i_flash_wr_erase(ev[5]),
    .i_rtc_fail_det_en(ev[7]), .i_rtc_clk_slow(ev[7]),
    .i_rtc_alarm_en(ev[6]), .i_rtc_alarm_match(ev[6]),
    .o_sys_reset(sys_reset), .o_reset_pin_out(pin_out),
    .o_reset_pin_oe_n(pin_oe_n), .o_supply_mon_en(smon),
    .o_wdt_enable(wdt_en), .o_wdt_tick(tick)
  );

  rstc_src_model u_model (
    .i_clk(clk), .i_pin_req(pin_req), .i_cmp_trip(cmp_trip),
    .i_clk_stop(clk_stop), .o_pin_drive_n(model_pin_n),
    .o_comparator_out(cmp_out), .o_core_clock(core_clk)
  );

  // ------------------------------------------------------------
  // Compare and bus tasks
  // ------------------------------------------------------------
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    cmp_bit(pready, 1'b1);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wreg(input logic [7:0] d);
    apb(1'b1, rstc_pkg::RSTC_CAUSE_ADDR, {24'h0, d});
  endtask : wreg

  task automatic wait_sys(input logic lvl);
    int n;
    n = 0;
    while (sys_reset !== lvl && n < 300) begin
      @(posedge clk);
      n++;
    end
    cmp_bit(sys_reset, lvl);
  endtask : wait_sys

  // Waits out one system reset, releases all sources, checks the cause
  task automatic finish(input logic [7:0] exp, input logic exp_oe);
    wait_sys(1'b1);
    repeat (2) @(posedge clk);
    cmp_bit(pin_oe_n, exp_oe);
    cmp_bit(pin_out, 1'b0);
    ev <= 8'h00;
    sup <= 1'b0;
    pin_req <= 1'b0;
    cmp_trip <= 1'b0;
    clk_stop <= 1'b0;
    wait_sys(1'b0);
    @(posedge clk);
    cmp_bit(wdt_en, 1'b1);
    apb(1'b0, rstc_pkg::RSTC_CAUSE_ADDR, 32'h0);
    cmp_val(rdata, {24'h0, exp});
  endtask : finish

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    int n;
    clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; lp = 0; wake = 0; ev = 0; fwe = 0; sup = 0;
    pin_req = 0; cmp_trip = 0; clk_stop = 0; wdis = 0; mismatches = 0; checks_done = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, rstc_pkg::RSTC_CAUSE_ADDR, 32'h0);
    cmp_val(rdata, 32'h02);
    cmp_bit(smon, 1'b1);
    // Watchdog tick spacing
    n = 0;
    while (tick !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < 40);
    cmp_val(32'(n), 32'h0c);
    // Software disable holds until the next reset
    wdis <= 1'b1;
    @(posedge clk);
    wdis <= 1'b0;
    @(posedge clk);
    cmp_bit(wdt_en, 1'b0);
    // Unmapped address refused, no reset forced
    apb(1'b1, 12'h3c0, 32'h10);
    cmp_bit(serr, 1'b1);
    apb(1'b0, 12'h3c0, 32'h0);
    cmp_val(rdata, 32'h0);
    cmp_bit(sys_reset, 1'b0);
    wreg(8'h12);
    finish(8'h10, 1'b1);
    lp <= 1'b1;
    pin_req <= 1'b1;
    finish(8'h01, 1'b1);
    wreg(8'h22);
    cmp_trip <= 1'b1;
    repeat (10) @(posedge clk);
    cmp_bit(sys_reset, 1'b0);
    wake <= 1'b1;
    finish(8'h20, 1'b1);
    lp <= 1'b0;
    wake <= 1'b0;
    // Watchdog then clock loss, held off in low power
    for (int i = 0; i < 2; i++) begin
      wreg(i ? 8'h26 : 8'h22);
      lp <= 1'b1;
      if (i) clk_stop <= 1'b1;
      else ev[0] <= 1'b1;
      repeat (100) @(posedge clk);
      cmp_bit(sys_reset, 1'b0);
      lp <= 1'b0;
      finish(i ? 8'h04 : 8'h08, 1'b1);
    end
    fwe <= 1'b1;
    for (int k = 1; k < 5; k++) begin
      ev[k] <= 1'b1;
      @(posedge clk);
      ev[k] <= 1'b0;
      finish(8'h40, 1'b1);
    end
    wreg(8'h00);
    wreg(8'h10);
    finish(8'h10, 1'b1);
    cmp_bit(smon, 1'b0);
    ev[5] <= 1'b1;
    @(posedge clk);
    ev[5] <= 1'b0;
    finish(8'h40, 1'b1);
    for (int k = 6; k < 8; k++) begin
      wreg(8'h80);
      ev[k] <= 1'b1;
      finish(8'h80, 1'b1);
    end
    wreg(8'h02);
    sup <= 1'b1;
    finish(8'h02, 1'b0);
    cmp_bit(smon, 1'b1);
    test_done();
  end

  // Watchdog on the whole run
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule : tb_top
